// *** rtl/usr_pkg.sv ***
// package: register map and field layout of the stall/resume/clear block
`default_nettype none
package usr_pkg;
  // offsets are word indices; byte address is four times the index
  localparam logic [15:0] OFF_CTRL     = 16'hFF64;
  localparam logic [15:0] OFF_CLR      = 16'hFF65;
  localparam logic [15:0] OFF_DSTATE   = 16'hFF68;
  localparam logic [15:0] OFF_IRQ_STAT = 16'hFF70;
  localparam logic [15:0] OFF_IRQ_EN   = 16'hFF74;
  localparam logic [15:0] OFF_IRQ_CLR  = 16'hFF78;
  localparam int          BIT_RESUME   = 0;
  localparam int          BIT_STALL    = 3;
  localparam int          BIT_RWAKE    = 0;
  localparam logic [7:0]  RST_CTRL     = 8'h00;
  localparam logic [7:0]  RST_CLR      = 8'h00;
  localparam logic [7:0]  RST_DSTATE   = 8'h00;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  typedef enum logic [1:0] {
    CF_DEVICE, CF_EP0, CF_EP1, CF_EP2
  } usr_cf_target_t;
endpackage : usr_pkg
`default_nettype wire

// *** rtl/usr_stall_resume.sv ***
// stall / resume control and clear-feature flags with an axi4-lite slave
//
// Our own choice: the AXI4-Lite register port.
`default_nettype none
module usr_stall_resume (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [17:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [17:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        status_stage_done,
  input  wire logic [1:0]  cf_target,
  input  wire logic        cf_request,
  input  wire logic        setup_token,
  input  wire logic        bad_request,
  input  wire logic        ep0_overrun,
  output logic             resume_drive,
  output logic             ep0_stall,
  output logic             irq
);

  typedef struct packed {
    logic        aw_got;
    logic [15:0] aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  ctrl;
    logic [7:0]  dstate;
    logic [7:0]  flags;
    logic        pend;
    logic [1:0]  pend_tgt;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_en;
  } usr_state_t;

  usr_state_t s_q;
  usr_state_t s_d;

  logic        do_wr;
  logic        do_rd;
  logic [7:0]  set_flags;
  logic [3:0]  ev;
  logic [15:0] rd_idx;

  // registers are word indexed; byte lanes below a word are ignored
  assign rd_idx = s_axi_araddr[17:2];

  //////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready  = !s_q.w_got && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign resume_drive  = s_q.ctrl[usr_pkg::BIT_RESUME];
  assign ep0_stall     = s_q.ctrl[usr_pkg::BIT_STALL];
  assign irq           = |(s_q.irq_stat & s_q.irq_en);

  assign do_wr = s_q.aw_got && s_q.w_got && !s_q.bvalid;
  assign do_rd = s_axi_arvalid && s_axi_arready;

  always_comb begin
    set_flags = 8'h00;
    if (s_q.pend && status_stage_done) begin
      unique case (usr_pkg::usr_cf_target_t'(s_q.pend_tgt))
        usr_pkg::CF_DEVICE: set_flags = 8'h01;
        usr_pkg::CF_EP0:    set_flags = 8'h02;
        usr_pkg::CF_EP1:    set_flags = 8'h04;
        usr_pkg::CF_EP2:    set_flags = 8'h08;
      endcase
    end
  end

  assign ev = {ep0_overrun, bad_request, setup_token, |set_flags};

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_got  = 1'b1;
      s_d.aw_addr = s_axi_awaddr[17:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_got  = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (cf_request) begin
      s_d.pend     = 1'b1;
      s_d.pend_tgt = cf_target;
    end else if (s_q.pend && status_stage_done) begin
      s_d.pend = 1'b0;
    end
    // setup clears stall; a fault in the same cycle wins
    if (setup_token) begin
      s_d.ctrl[usr_pkg::BIT_STALL] = 1'b0;
    end
    if (do_wr) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = usr_pkg::RESP_OKAY;
      unique case (s_q.aw_addr)
        usr_pkg::OFF_CTRL: begin
          if (s_q.w_strb[0]) begin
            s_d.ctrl[usr_pkg::BIT_STALL] = s_q.w_data[usr_pkg::BIT_STALL];
            if (s_q.dstate[usr_pkg::BIT_RWAKE]) begin
              s_d.ctrl[usr_pkg::BIT_RESUME] =
                s_q.w_data[usr_pkg::BIT_RESUME];
            end
          end
        end
        usr_pkg::OFF_DSTATE: begin
          if (s_q.w_strb[0]) begin
            s_d.dstate = {7'h00, s_q.w_data[usr_pkg::BIT_RWAKE]};
          end
        end
        usr_pkg::OFF_IRQ_EN: begin
          if (s_q.w_strb[0]) begin
            s_d.irq_en = s_q.w_data[3:0];
          end
        end
        usr_pkg::OFF_IRQ_CLR: begin
          if (s_q.w_strb[0]) begin
            s_d.irq_stat = s_q.irq_stat & ~s_q.w_data[3:0];
          end
        end
        default: s_d.bresp = usr_pkg::RESP_SLVERR; // read-only or unmapped
      endcase
    end
    if (bad_request || ep0_overrun) begin
      s_d.ctrl[usr_pkg::BIT_STALL] = 1'b1;
    end
    if (do_rd) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = usr_pkg::RESP_OKAY;
      s_d.rdata  = 32'h0000_0000;
      unique case (rd_idx)
        usr_pkg::OFF_CTRL:     s_d.rdata = {24'h000000, s_q.ctrl};
        usr_pkg::OFF_DSTATE:   s_d.rdata = {24'h000000, s_q.dstate};
        usr_pkg::OFF_IRQ_STAT: s_d.rdata = {28'h0000000, s_q.irq_stat};
        usr_pkg::OFF_IRQ_EN:   s_d.rdata = {28'h0000000, s_q.irq_en};
        usr_pkg::OFF_CLR: begin
          s_d.rdata = {24'h000000, s_q.flags};
          s_d.flags = 8'h00;
        end
        default: s_d.rresp = usr_pkg::RESP_SLVERR;
      endcase
    end
    // a flag set in the read cycle survives the clear
    s_d.flags    = s_d.flags | set_flags;
    s_d.irq_stat = s_d.irq_stat | ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q        <= '0;
      s_q.ctrl   <= usr_pkg::RST_CTRL;
      s_q.dstate <= usr_pkg::RST_DSTATE;
      s_q.flags  <= usr_pkg::RST_CLR;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  resume_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_wr && s_q.aw_addr == usr_pkg::OFF_CTRL && !s_q.dstate[0])
      |=> $stable(resume_drive))
    else $error("resume bit changed without remote wake");
  resume_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (resume_drive && !do_wr) |=> resume_drive)
    else $error("resume dropped on its own");
  flag_status_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_q.flags[0]) |-> $past(status_stage_done))
    else $error("flag set without status stage");
  read_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_rd && rd_idx == usr_pkg::OFF_CLR && !status_stage_done)
      |=> s_q.flags == 8'h00)
    else $error("flags not cleared by read");
  flag_upper_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.flags[7:4] == 4'h0)
    else $error("flag upper bits set");
  stall_setup_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (setup_token && !bad_request && !ep0_overrun && !do_wr) |=> !ep0_stall)
    else $error("stall not cleared by setup");
  stall_fault_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (bad_request || ep0_overrun) |=> ep0_stall)
    else $error("stall not set on fault");
  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == |(s_q.irq_stat & s_q.irq_en))
    else $error("irq level wrong");
  resp_time_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_rd |=> s_axi_rvalid)
    else $error("read answer late");
  wr_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_wr |=> s_axi_bvalid)
    else $error("write answer late");
  bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
    else $error("write response dropped early");
  rvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
    else $error("read response dropped early");
  aw_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
    else $error("write taken while response pending");
  flag_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !do_rd |=> ((s_q.flags & $past(s_q.flags)) == $past(s_q.flags)))
    else $error("flag lost without read");
  flag_data_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_rd && rd_idx == usr_pkg::OFF_CLR)
      |=> s_axi_rdata[7:0] == $past(s_q.flags))
    else $error("flag read data wrong");

  flag_read_c: cover property (@(posedge aclk) disable iff (!aresetn)
    do_rd && rd_idx == usr_pkg::OFF_CLR && s_q.flags != 8'h00);
  stall_fault_c: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(ep0_stall) && !$past(do_wr));
  irq_on_c: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(irq));
  resume_on_c: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(resume_drive));
  stall_clr_c: cover property (@(posedge aclk) disable iff (!aresetn)
    ep0_stall && setup_token);

endmodule : usr_stall_resume
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the stall/resume/clear-feature block
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, resume_drive, ep0_stall, irq;
  logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp, cf_target, r;
  logic cf_request, status_stage_done, setup_token, bad_request;
  logic ep0_overrun;
  logic [7:0] d;
  int fails = 0, total_checks = 0, cycles = 0;
  usr_stall_resume DUT (.*);
  usr_host_model HOST (.*);
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge aclk);
    s_axi_awaddr <= {a, 2'b00};
    s_axi_wdata <= {24'h000000, v};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(posedge aclk);
    s_axi_araddr <= {a, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
  endtask : rd
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(usr_pkg::OFF_CTRL);
    `CHK(d, usr_pkg::RST_CTRL)
    rd(usr_pkg::OFF_CLR);
    `CHK(d, usr_pkg::RST_CLR)
    wr(usr_pkg::OFF_CTRL, 8'h01);
    rd(usr_pkg::OFF_CTRL);
    `CHK({d, resume_drive}, 9'h000)
    wr(usr_pkg::OFF_DSTATE, 8'h01);
    wr(usr_pkg::OFF_CTRL, 8'h01);
    repeat (40) @(posedge aclk);
    `CHK(resume_drive, 1'b1)
    wr(usr_pkg::OFF_CTRL, 8'h00);
    `CHK(resume_drive, 1'b0)
    // flag only after status stage, cleared by the read
    for (int t = 0; t < 4; t++) begin
      HOST.evt(5'h10, t[1:0]);
      rd(usr_pkg::OFF_CLR);
      `CHK(d, 8'h00)
      HOST.evt(5'h08, 2'h0);
      `CHK(irq, 1'b0)
      rd(usr_pkg::OFF_CLR);
      `CHK(d, 8'h01 << t)
      rd(usr_pkg::OFF_CLR);
      `CHK(d, 8'h00)
    end
    wr(usr_pkg::OFF_IRQ_EN, 8'h01);
    @(posedge aclk);
    `CHK(irq, 1'b1)
    wr(usr_pkg::OFF_IRQ_CLR, 8'h01);
    @(posedge aclk);
    `CHK(irq, 1'b0)
    wr(usr_pkg::OFF_CTRL, 8'h08);
    `CHK(ep0_stall, 1'b1)
    HOST.evt(5'h04, 2'h0);
    `CHK(ep0_stall, 1'b0)
    HOST.evt(5'h02, 2'h0);
    `CHK(ep0_stall, 1'b1)
    HOST.evt(5'h04, 2'h0);
    HOST.evt(5'h01, 2'h0);
    `CHK(ep0_stall, 1'b1)
    rd(usr_pkg::OFF_IRQ_STAT);
    `CHK(d, 8'h0E)
    rd(16'h0000);
    `CHK({r, d}, {usr_pkg::RESP_SLVERR, 8'h00})
    wr(usr_pkg::OFF_CLR, 8'hFF);
    `CHK(r, usr_pkg::RESP_SLVERR)
    finish_test();
  end
endmodule : testbench
`default_nettype wire

// *** test/usr_host_model.sv ***
// host-side model pulsing the usb event inputs of the block
`default_nettype none
module usr_host_model (
  input  wire logic  aclk,
  output logic [1:0] cf_target,
  output logic       cf_request,
  output logic       status_stage_done,
  output logic       setup_token,
  output logic       bad_request,
  output logic       ep0_overrun
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cf_target = 2'h0;
    {cf_request, status_stage_done, setup_token, bad_request,
     ep0_overrun} = 5'h00;
  end
  // one-cycle pulse; target garbled once the request is gone
  task automatic evt(input logic [4:0] m, input logic [1:0] t);
    @(posedge aclk);
    cf_target <= t;
    {cf_request, status_stage_done, setup_token, bad_request,
     ep0_overrun} <= m;
    @(posedge aclk);
    cf_target <= ~t;
    {cf_request, status_stage_done, setup_token, bad_request,
     ep0_overrun} <= 5'h00;
    @(posedge aclk);
  endtask : evt
endmodule : usr_host_model
`default_nettype wire
